/* File: hw/supervisor_pkg.sv */
// Shared constants and carriers for the detector supervisor
package supervisor_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_DIAG = 8'h08;
  localparam logic [7:0] OFF_HV_LIMIT = 8'h0C;
  localparam logic [7:0] OFF_AUX_LIMIT = 8'h10;
  localparam logic [7:0] OFF_OOL_LIMIT = 8'h14;
  localparam logic [7:0] OFF_SAMPLE_IDX = 8'h18;
  localparam logic [7:0] OFF_SAMPLE_DATA = 8'h1C;
  // Control register bit positions (write one to act)
  localparam int CTRL_GO_OPER = 0;
  localparam int CTRL_WD_ENABLE = 1;
  localparam int CTRL_WD_SERVICE = 2;
  localparam int CTRL_CMD_RESET = 3;
  localparam int CTRL_HK_START = 4;
  localparam int CTRL_HK_STOP = 5;
  localparam int CTRL_DUMP = 6;
  localparam int CTRL_HV_ON = 7;
  localparam int CTRL_HV_OFF = 8;
  localparam int CTRL_RST_TEST = 9;
  localparam int CTRL_WD_TEST = 10;
  // Diagnostic flag positions
  localparam int DIAG_RESET = 0;
  localparam int DIAG_GLITCH = 1;
  localparam int DIAG_TRIP = 2;
  localparam int DIAG_WDOG = 3;
  // Reset cause codes
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_POR = 4'h1;
  localparam logic [3:0] CAUSE_WDOG = 4'h2;
  localparam logic [3:0] CAUSE_CMD = 4'h3;
  localparam logic [3:0] CAUSE_UPSET = 4'h4;
  localparam logic [3:0] CAUSE_RST_TEST = 4'h5;
  localparam logic [3:0] CAUSE_WD_TEST = 4'h6;
  localparam logic [3:0] CAUSE_UNKNOWN = 4'h7;
  // Power-on defaults of protection parameters
  localparam logic [15:0] HV_LIMIT_RST = 16'h0096;
  localparam logic [15:0] AUX_LIMIT_RST = 16'h00EB;
  localparam logic [15:0] OOL_LIMIT_RST = 16'h0003;
  // Stream and timing figures
  localparam int HK_WORDS_PER_S = 512;
  localparam int HK_PACKET_WORDS = 512;
  localparam int HK_IDX_W = 9;
  localparam int WDOG_TIMEOUT_S = 10;
  localparam int CLK_HZ_DEFAULT = 50_000_000;
  // Current conversion from the converter logic
  typedef struct packed {
    logic valid;
    logic [15:0] hv_cur;
    logic [15:0] aux_cur;
  } adc_sample_s;
  // One housekeeping or dump word
  typedef struct packed {
    logic valid;
    logic dump;
    logic [31:0] data;
  } hk_word_s;
endpackage

/* File: hw/detector_supervisor.sv */
// Reset supervisor, overcurrent guard and housekeeping streamer
//
// Contract
// - Housekeeping streams 512 32-bit words per second.
// - Dump command sends separate 512-word packet.
// - Power-on clears memory, then waits in boot.
// - Watchdog disabled at boot, enabled by command.
// - Unserviced enabled watchdog resets after ten seconds.
// - Upset or command also forces boot state.
// - Any reset leaves high voltage off.
// - Non-power-on resets keep memory contents.
// - Housekeeping reports reset and its cause.
// - Test and unknown resets also reach boot.
// - Every current sample outside the power-on memory clear is stored in memory.
// - With nonzero threshold, first over-limit sample posts diagnostic only.
// - Further over-limit samples counted without diagnostic.
// - In-limit sample clears consecutive counter.
// - Count exceeded removes high voltage, reports.
// - High voltage returns only by command.
// - Out-of-limits threshold is a writable register.
// - Protection defaults load at power-on, writable after.
`timescale 1ns/10ps
module detector_supervisor #(
  parameter int unsigned CLK_HZ = supervisor_pkg::CLK_HZ_DEFAULT
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire supervisor_pkg::adc_sample_s adc_in,
  input wire logic upset_pin,
  input wire logic unknown_reset_pin,
  output supervisor_pkg::hk_word_s hk_out,
  output logic hv_power_en,
  output logic boot_state,
  output logic watchdog_reset_event
);
  import supervisor_pkg::*;

  typedef enum logic [1:0] {ST_INIT, ST_BOOT, ST_OPER} sup_state_e;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sup_state_e state_r, state_nxt;
  logic [31:0] smem [HK_PACKET_WORDS];
  logic [HK_IDX_W-1:0] init_idx_r, wr_ptr_r, rd_idx_r, word_idx_r;
  logic [31:0] acc_r;
  logic [3:0] wd_sec_r, cause_r;
  logic [3:0] diag_r, diag_nxt;
  logic [15:0] hv_limit_r, aux_limit_r, ool_limit_r, ool_cnt_r, over_total_r;
  logic [31:0] last_sample_r;
  logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic wd_en_r, hk_en_r, dump_pend_r, dump_act_r, trip_r;

  // Register port decode
  wire wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
  wire wr_diag = reg_wr && reg_addr == OFF_DIAG;
  wire cmd_go = wr_ctrl && reg_wdata[CTRL_GO_OPER];
  wire cmd_wd_en = wr_ctrl && reg_wdata[CTRL_WD_ENABLE];
  wire cmd_wd_svc = wr_ctrl && reg_wdata[CTRL_WD_SERVICE];
  wire cmd_reset = wr_ctrl && reg_wdata[CTRL_CMD_RESET];
  wire cmd_hk_on = wr_ctrl && reg_wdata[CTRL_HK_START];
  wire cmd_hk_off = wr_ctrl && reg_wdata[CTRL_HK_STOP];
  wire cmd_dump = wr_ctrl && reg_wdata[CTRL_DUMP];
  wire cmd_hv_on = wr_ctrl && reg_wdata[CTRL_HV_ON];
  wire cmd_hv_off = wr_ctrl && reg_wdata[CTRL_HV_OFF];
  wire cmd_rst_test = wr_ctrl && reg_wdata[CTRL_RST_TEST];
  wire cmd_wd_test = wr_ctrl && reg_wdata[CTRL_WD_TEST];

  // Pin edges, read only after two stages
  wire upset_rise = pin_s2_r[0] && !pin_s3_r[0];
  wire unknown_rise = pin_s2_r[1] && !pin_s3_r[1];

  // Word tick from a fractional accumulator; second tick at word wrap
  wire [31:0] acc_sum = acc_r + 32'(HK_WORDS_PER_S);
  wire word_tick = acc_sum >= CLK_HZ;
  wire [31:0] acc_nxt = word_tick ? acc_sum - CLK_HZ : acc_sum;
  wire second_tick = word_tick && word_idx_r == HK_IDX_W'(HK_PACKET_WORDS - 1);

  wire wd_fire = wd_en_r && second_tick && wd_sec_r == 4'(WDOG_TIMEOUT_S - 1) && !cmd_wd_svc;
  wire soft_rst = wd_fire || cmd_reset || upset_rise || unknown_rise || cmd_rst_test || cmd_wd_test;
  wire [3:0] cause_nxt = wd_fire ? CAUSE_WDOG :
                         cmd_wd_test ? CAUSE_WD_TEST :
                         cmd_rst_test ? CAUSE_RST_TEST :
                         cmd_reset ? CAUSE_CMD :
                         upset_rise ? CAUSE_UPSET : CAUSE_UNKNOWN;

  // Overcurrent compare; a zero limit disables that channel
  wire sample_ok = adc_in.valid && state_r != ST_INIT;
  wire hv_over = hv_limit_r != 16'h0000 && adc_in.hv_cur > hv_limit_r;
  wire aux_over = aux_limit_r != 16'h0000 && adc_in.aux_cur > aux_limit_r;
  wire over = sample_ok && (hv_over || aux_over);
  wire [15:0] ool_inc = (ool_cnt_r == 16'hFFFF) ? ool_cnt_r : ool_cnt_r + 16'h0001;
  wire trip_now = over && ool_inc > ool_limit_r;
  wire glitch_now = over && ool_cnt_r == 16'h0000;

  // Housekeeping content by word slot
  wire [7:0] st_flags = {4'h0, trip_r, wd_en_r, hv_power_en, 1'b0};
  wire [31:0] hk_w0 = {word_idx_r, 7'h00, cause_r, diag_r, st_flags | {6'h00, 2'(state_r)}};
  wire [31:0] hk_w1 = {ool_cnt_r, ool_limit_r};
  wire [31:0] hk_w3 = {over_total_r, 16'(wr_ptr_r)};
  wire [31:0] hk_data = (word_idx_r[1:0] == 2'b00) ? hk_w0 :
                        (word_idx_r[1:0] == 2'b01) ? hk_w1 :
                        (word_idx_r[1:0] == 2'b10) ? last_sample_r : hk_w3;
  wire dump_start = word_tick && word_idx_r == '0 && dump_pend_r;
  wire dump_now = dump_act_r || dump_start;

  // Read mux
  wire [31:0] status_w = {16'h0000, 4'h0, cause_r, trip_r, dump_act_r, hk_en_r, wd_en_r,
                          hv_power_en, boot_state, 2'(state_r)};
  wire [31:0] rd_mux = (reg_addr == OFF_CTRL) ? {29'h0000_0000, hv_power_en, hk_en_r, wd_en_r} :
                       (reg_addr == OFF_STATUS) ? status_w :
                       (reg_addr == OFF_DIAG) ? {28'h000_0000, diag_r} :
                       (reg_addr == OFF_HV_LIMIT) ? {16'h0000, hv_limit_r} :
                       (reg_addr == OFF_AUX_LIMIT) ? {16'h0000, aux_limit_r} :
                       (reg_addr == OFF_OOL_LIMIT) ? {16'h0000, ool_limit_r} :
                       (reg_addr == OFF_SAMPLE_IDX) ? {23'h00_0000, rd_idx_r} :
                       (reg_addr == OFF_SAMPLE_DATA) ? smem[rd_idx_r] : 32'h0000_0000;

  // State sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_INIT: if (init_idx_r == HK_IDX_W'(HK_PACKET_WORDS - 1)) state_nxt = ST_BOOT;
      ST_BOOT: if (cmd_go) state_nxt = ST_OPER;
      ST_OPER: ;
    endcase
    // every reset kind ends in boot
    if (soft_rst && state_r != ST_INIT) begin
      state_nxt = ST_BOOT;
    end
  end

  // Diagnostic flags; a set beats a same-cycle clear
  always_comb begin
    diag_nxt = wr_diag ? diag_r & ~reg_wdata[3:0] : diag_r;
    if (soft_rst) diag_nxt[DIAG_RESET] = 1'b1;
    if (wd_fire) diag_nxt[DIAG_WDOG] = 1'b1;
    if (glitch_now) diag_nxt[DIAG_GLITCH] = 1'b1;
    if (trip_now) diag_nxt[DIAG_TRIP] = 1'b1;
  end

  // Two-stage synchronisers and edge history
  always_ff @(posedge core_clk) begin
    pin_s1_r <= {unknown_reset_pin, upset_pin};
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end

  // Sample memory: no reset, so evidence survives soft resets
  // kept across soft resets
  always_ff @(posedge core_clk) begin
    if (state_r == ST_INIT) begin
      smem[init_idx_r] <= 32'h0000_0000;
    end else if (sample_ok) begin
      smem[wr_ptr_r] <= {adc_in.hv_cur, adc_in.aux_cur};
    end
  end

  // Sequencing, pointers and reset cause
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_INIT;
      init_idx_r <= '0;
      wr_ptr_r <= '0;
      cause_r <= CAUSE_POR;
      diag_r <= 4'h1;
    end else begin
      state_r <= state_nxt;
      init_idx_r <= (state_r == ST_INIT) ? init_idx_r + 1'b1 : init_idx_r;
      wr_ptr_r <= sample_ok ? wr_ptr_r + 1'b1 : wr_ptr_r;
      cause_r <= soft_rst ? cause_nxt : cause_r;
      diag_r <= diag_nxt;
    end
  end

  // Protection parameters
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hv_limit_r <= HV_LIMIT_RST;
      aux_limit_r <= AUX_LIMIT_RST;
      ool_limit_r <= OOL_LIMIT_RST;
      rd_idx_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == OFF_HV_LIMIT) hv_limit_r <= reg_wdata[15:0];
      if (reg_addr == OFF_AUX_LIMIT) aux_limit_r <= reg_wdata[15:0];
      if (reg_addr == OFF_OOL_LIMIT) ool_limit_r <= reg_wdata[15:0];
      if (reg_addr == OFF_SAMPLE_IDX) rd_idx_r <= reg_wdata[HK_IDX_W-1:0];
    end
  end

  // Overcurrent counting
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ool_cnt_r <= 16'h0000;
      over_total_r <= 16'h0000;
      last_sample_r <= 32'h0000_0000;
    end else if (sample_ok) begin
      last_sample_r <= {adc_in.hv_cur, adc_in.aux_cur};
      ool_cnt_r <= over ? ool_inc : 16'h0000;
      over_total_r <= over ? over_total_r + 16'h0001 : over_total_r;
    end
  end

  // High voltage enable and trip latch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hv_power_en <= 1'b0;
      trip_r <= 1'b0;
    end else if (soft_rst) begin
      hv_power_en <= 1'b0;
      // Same-cycle trip still latches
      trip_r <= trip_r || trip_now;
    end else if (trip_now) begin
      hv_power_en <= 1'b0;
      trip_r <= 1'b1;
    end else if (cmd_hv_off) begin
      hv_power_en <= 1'b0;
    end else if (cmd_hv_on && state_r == ST_OPER) begin
      hv_power_en <= 1'b1;
      trip_r <= 1'b0;
    end
  end

  // Watchdog enable and second counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wd_en_r <= 1'b0;
      wd_sec_r <= 4'h0;
      watchdog_reset_event <= 1'b0;
    end else begin
      watchdog_reset_event <= wd_fire;
      if (soft_rst) begin
        wd_en_r <= 1'b0;
        wd_sec_r <= 4'h0;
      end else if (cmd_wd_en || cmd_wd_svc) begin
        wd_en_r <= wd_en_r || cmd_wd_en;
        wd_sec_r <= 4'h0;
      end else if (wd_en_r && second_tick) begin
        wd_sec_r <= wd_sec_r + 4'h1;
      end
    end
  end

  // Time base and word slot counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_r <= 32'h0000_0000;
      word_idx_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      word_idx_r <= word_tick ? word_idx_r + 1'b1 : word_idx_r;
    end
  end

  // Housekeeping and dump streaming
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hk_en_r <= 1'b0;
      dump_pend_r <= 1'b0;
      dump_act_r <= 1'b0;
      hk_out <= '0;
    end else begin
      hk_en_r <= (hk_en_r || cmd_hk_on) && !cmd_hk_off;
      // dump waits for a packet boundary
      dump_pend_r <= (dump_pend_r && !dump_start) || cmd_dump;
      if (dump_start) begin
        dump_act_r <= 1'b1;
      end else if (second_tick) begin
        dump_act_r <= 1'b0;
      end
      hk_out.valid <= word_tick && (hk_en_r || dump_now);
      hk_out.dump <= word_tick ? dump_now : hk_out.dump;
      if (word_tick) begin
        hk_out.data <= dump_now ? smem[word_idx_r] : hk_data;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      boot_state <= 1'b1;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      boot_state <= state_nxt != ST_OPER;
    end
  end

  // Cycles since the last stream word, for the rate check
  logic [31:0] word_gap_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      word_gap_r <= 32'hFFFF_FFFF;
    end else if (hk_out.valid) begin
      word_gap_r <= 32'h0000_0001;
    end else if (word_gap_r != 32'hFFFF_FFFF) begin
      word_gap_r <= word_gap_r + 32'h0000_0001;
    end
  end

  sequence s_fire_and_report;
    watchdog_reset_event && boot_state;
  endsequence
  sequence s_trip_report;
    !hv_power_en && trip_r && diag_r[DIAG_TRIP];
  endsequence

  AST_POR_INIT: assert property ($fell(sys_rst) |-> state_r == ST_INIT)
    else $error("power-on did not start memory clear");
  AST_WD_OFF_BOOT: assert property (soft_rst |=> !wd_en_r && wd_sec_r == 4'h0)
    else $error("watchdog not disabled on boot entry");
  AST_WD_FIRE: assert property (wd_fire |=> s_fire_and_report)
    else $error("watchdog expiry did not reach boot");
  AST_SOFT_BOOT: assert property (soft_rst && state_r != ST_INIT |=> boot_state && state_r == ST_BOOT)
    else $error("reset did not return to boot");
  AST_HV_OFF_RESET: assert property (soft_rst |=> !hv_power_en)
    else $error("high voltage on after reset");
  AST_RESET_DIAG: assert property (soft_rst |=> diag_r[DIAG_RESET] && cause_r == $past(cause_nxt))
    else $error("reset not reported");
  AST_GLITCH: assert property (glitch_now && ool_limit_r != 16'h0000 && !soft_rst && !wr_ctrl
                               |=> diag_r[DIAG_GLITCH] && hv_power_en == $past(hv_power_en))
    else $error("first over-limit handled wrongly");
  AST_OOL_CLEAR: assert property (sample_ok && !over |=> ool_cnt_r == 16'h0000)
    else $error("in-limit sample did not clear count");
  AST_TRIP: assert property (trip_now |=> s_trip_report)
    else $error("sustained over-limit did not trip");
  AST_NO_AUTO_HV: assert property (!hv_power_en && !cmd_hv_on |=> !hv_power_en)
    else $error("high voltage returned without command");
  AST_WORD_RATE: assert property (hk_out.valid |-> word_gap_r >= CLK_HZ / HK_WORDS_PER_S)
    else $error("housekeeping words too close");

  // Counting, storage, dump and watchdog command checks
  AST_SILENT_COUNT: assert property (over && !glitch_now && !wr_diag
      |=> diag_r[DIAG_GLITCH] == $past(diag_r[DIAG_GLITCH]) && ool_cnt_r == $past(ool_inc))
    else $error("repeat over-limit not counted silently");
  AST_SAMPLE_STORE: assert property (sample_ok
      |=> smem[$past(wr_ptr_r)] == {$past(adc_in.hv_cur), $past(adc_in.aux_cur)})
    else $error("current sample not stored");
  AST_DUMP_START: assert property (dump_start |=> hk_out.valid && hk_out.dump && dump_act_r)
    else $error("dump packet did not start");
  AST_PARAM_DEFAULTS: assert property ($fell(sys_rst) |-> hv_limit_r == HV_LIMIT_RST
      && aux_limit_r == AUX_LIMIT_RST && ool_limit_r == OOL_LIMIT_RST)
    else $error("protection defaults not loaded");
  AST_WD_SERVICE: assert property (cmd_wd_svc |=> wd_sec_r == 4'h0)
    else $error("watchdog service did not restart count");
  AST_WD_CMD_ONLY: assert property (!wd_en_r && !cmd_wd_en |=> !wd_en_r)
    else $error("watchdog enabled without command");
endmodule // detector_supervisor

/* File: bench/hk_sink.sv */
// Host-side sink that tallies housekeeping and dump words
`timescale 1ns/10ps
module hk_sink (
  input wire logic core_clk,
  input wire logic clr,
  input wire supervisor_pkg::hk_word_s hk_out,
  output int n_word,
  output int n_dump,
  output logic [31:0] first_dump
);
  import supervisor_pkg::*;
  // Count words in a window opened by clr
  // word and dump word tally
  always_ff @(posedge core_clk) begin
    if (clr) begin
      n_word <= 0;
      n_dump <= 0;
    end else if (hk_out.valid) begin
      n_word <= n_word + 1;
      if (hk_out.dump) begin
        n_dump <= n_dump + 1;
      end
      if (hk_out.dump && n_dump == 0) begin
        first_dump <= hk_out.data; // First word of packet
      end
    end
  end
endmodule // hk_sink

/* File: bench/detector_supervisor_bench.sv */
// Self-checking bench for the detector supervisor
`timescale 1ns/10ps
module detector_supervisor_bench;
  import supervisor_pkg::*;
  localparam int unsigned HZ = 2048;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  adc_sample_s adc_in = '0;
  logic upset_pin = 1'b0;
  logic unknown_reset_pin = 1'b0;
  hk_word_s hk_out;
  logic hv_power_en;
  logic boot_state;
  logic watchdog_reset_event;
  logic clr = 1'b0;
  int n_word;
  int n_dump;
  logic [31:0] first_dump;
  logic [31:0] v;
  int n_mismatch = 0;
  int checked = 0;
  int bit_tab [3] = '{CTRL_CMD_RESET, CTRL_RST_TEST, CTRL_WD_TEST};
  logic [3:0] cause_tab [5] = '{CAUSE_CMD, CAUSE_RST_TEST, CAUSE_WD_TEST, CAUSE_UPSET, CAUSE_UNKNOWN};

  // Clock, one second is HZ cycles
  always #10 core_clk = ~core_clk;

  detector_supervisor #(.CLK_HZ(HZ)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_in(adc_in), .upset_pin(upset_pin),
    .unknown_reset_pin(unknown_reset_pin), .hk_out(hk_out), .hv_power_en(hv_power_en),
    .boot_state(boot_state), .watchdog_reset_event(watchdog_reset_event)
  );
  hk_sink sink (
    .core_clk(core_clk), .clr(clr), .hk_out(hk_out), .n_word(n_word), .n_dump(n_dump),
    .first_dump(first_dump)
  );

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus cycles, each ends at a falling edge so ports are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    chk(what, e, v & m);
  endtask
  task automatic ctl(input int b);
    wr(OFF_CTRL, 32'h1 << b);
  endtask
  // Back-to-back samples of one value
  task automatic smp(input logic [15:0] hv, input logic [15:0] aux, input int n);
    @(posedge core_clk);
    adc_in <= '{1'b1, hv, aux};
    repeat (n) @(posedge core_clk);
    adc_in.valid <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic clear();
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, about twice the expected run
  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk("boot at por", 1, boot_state);
    cyc(520);
    rdchk("diag", OFF_DIAG, 32'hF, 32'h1);
    rdchk("status", OFF_STATUS, 32'hFFF, 32'h105);
    rdchk("hv limit", OFF_HV_LIMIT, 32'hFFFF, 32'h0096);
    rdchk("aux limit", OFF_AUX_LIMIT, 32'hFFFF, 32'h00EB);
    rdchk("ool limit", OFF_OOL_LIMIT, 32'hFFFF, 32'h0003);
    rdchk("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0);
    wr(OFF_SAMPLE_IDX, 32'h5);
    rdchk("cleared mem", OFF_SAMPLE_DATA, 32'hFFFF_FFFF, 32'h0);
    ctl(CTRL_GO_OPER);
    ctl(CTRL_HV_ON);
    chk("hv on", 1, hv_power_en);
    wr(OFF_DIAG, 32'hF);
    smp(16'd200, 16'd0, 1);
    rdchk("first over", OFF_DIAG, 32'hF, 32'h2);
    chk("hv kept", 1, hv_power_en);
    wr(OFF_DIAG, 32'hF);
    smp(16'd200, 16'd0, 2);
    rdchk("silent count", OFF_DIAG, 32'hF, 32'h0);
    smp(16'd0, 16'd0, 1);
    smp(16'd200, 16'd0, 3);
    chk("count cleared", 1, hv_power_en);
    smp(16'd0, 16'd0, 1);
    smp(16'd0, 16'd300, 4);
    chk("trip", 0, hv_power_en);
    rdchk("trip diag", OFF_DIAG, 32'h4, 32'h4);
    cyc(50);
    chk("no self restore", 0, hv_power_en);
    wr(OFF_OOL_LIMIT, 32'h1);
    ctl(CTRL_HV_ON);
    chk("command restore", 1, hv_power_en);
    smp(16'd0, 16'd0, 1);
    smp(16'd200, 16'd0, 1);
    chk("limit one kept", 1, hv_power_en);
    smp(16'd200, 16'd0, 1);
    chk("limit one trip", 0, hv_power_en);
    wr(OFF_SAMPLE_IDX, 32'h8);
    rdchk("sample mem", OFF_SAMPLE_DATA, 32'hFFFF_FFFF, 32'h0000_012C);
    ctl(CTRL_HK_START);
    cyc(8);
    clear();
    cyc(2049);
    chk("hk words", 512, n_word);
    clear();
    ctl(CTRL_DUMP);
    cyc(4300);
    chk("dump words", 512, n_dump);
    chk("dump first", 32'h00C8_0000, first_dump);
    ctl(CTRL_HK_STOP);
    cyc(8);
    clear();
    cyc(2049);
    chk("hk stopped", 0, n_word);
    wr(OFF_DIAG, 32'hF);
    for (int i = 0; i < 5; i++) begin
      ctl(CTRL_GO_OPER);
      ctl(CTRL_HV_ON);
      chk("hv before reset", 1, hv_power_en);
      if (i < 3) begin
        ctl(bit_tab[i]);
      end else begin
        @(posedge core_clk);
        upset_pin <= (i == 3);
        unknown_reset_pin <= (i == 4);
        cyc(4);
        @(posedge core_clk);
        upset_pin <= 1'b0;
        unknown_reset_pin <= 1'b0;
      end
      cyc(8);
      chk("boot", 1, boot_state);
      chk("hv off", 0, hv_power_en);
      rdchk("cause", OFF_STATUS, 32'hF00, {20'h0, cause_tab[i], 8'h00});
      rdchk("reset diag", OFF_DIAG, 32'h1, 32'h1);
      wr(OFF_DIAG, 32'hF);
    end
    wr(OFF_SAMPLE_IDX, 32'h0);
    rdchk("kept mem", OFF_SAMPLE_DATA, 32'hFFFF_FFFF, 32'h00C8_0000);
    ctl(CTRL_GO_OPER);
    ctl(CTRL_WD_ENABLE);
    rdchk("wd on", OFF_STATUS, 32'h10, 32'h10);
    cyc(15000);
    chk("wd early", 0, boot_state);
    ctl(CTRL_WD_SERVICE);
    cyc(10000);
    chk("wd serviced", 0, boot_state);
    for (int i = 0; i < 12000 && watchdog_reset_event !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    chk("wd fired", 1, watchdog_reset_event);
    cyc(2);
    chk("wd boot", 1, boot_state);
    rdchk("wd status", OFF_STATUS, 32'hF10, 32'h200);
    rdchk("wd diag", OFF_DIAG, 32'h9, 32'h9);
    print_verdict();
  end
endmodule // detector_supervisor_bench
